// [hdl/mfr_host.sv]
`include "mfr_cfg.svh"

module mfr_host
  import mfr_pkg::*;
#(
  parameter int HALF = 4
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Flash pins
  output logic             sclk,
  output logic             cs_b,
  output mfr_sio_t         sio_drv,
  input  wire logic [3:0]  sio_in
);

  localparam int HW = (HALF > 1) ? $clog2(HALF) : 1;
  localparam logic [HW-1:0] HLAST = HW'(HALF - 1);

  mfr_ctrl_t   ctrl_reg;
  logic [7:0]  opc_reg;
  logic [7:0]  ind_reg;
  logic [31:0] addr_reg;
  logic [15:0] len_reg;
  logic [7:0]  rx_reg;
  logic        rx_full_reg;
  logic        err_reg;
  logic        enh_reg;
  mfr_state_t  state_reg;
  mfr_state_t  state_next;
  logic [HW-1:0] hcnt_reg;
  logic        half_reg;
  logic [7:0]  beats_reg;
  logic [7:0]  beats_next;
  logic [15:0] bytes_reg;
  logic [15:0] bytes_next;
  logic [31:0] sh_reg;
  logic [31:0] sh_next;
  logic [7:0]  rxsh_reg;
  logic [1:0]  lw_reg;
  logic [1:0]  lw_next;
  logic        ddr_reg;
  logic        ddr_next;
  logic        bstart_reg;
  logic        load;
  logic [3:0]  sio_s;

  // Pins from the flash pass two flops first
  mfr_sync #(.W(4)) u_sync (
    .clock (clock),
    .rst_b (rst_b),
    .d     (sio_in),
    .q     (sio_s)
  );

  // APB decode: one wait state, effects at the edge with pready high
  wire acc      = psel & penable & pready;
  wire ask      = psel & penable & ~pready;
  wire wr       = acc & pwrite;
  wire rd       = acc & ~pwrite;
  wire hit_ctrl = paddr == `MFR_A_CTRL;
  wire hit_cmd  = paddr == `MFR_A_CMD;
  wire hit_addr = paddr == `MFR_A_ADDR;
  wire hit_len  = paddr == `MFR_A_LEN;
  wire hit_go   = paddr == `MFR_A_GO;
  wire hit_stat = paddr == `MFR_A_STAT;
  wire hit_rxd  = paddr == `MFR_A_RXD;
  wire mapped   = hit_ctrl | hit_cmd | hit_addr | hit_len | hit_go | hit_stat | hit_rxd;
  wire busy     = state_reg != ST_IDLE;

  wire [31:0] rdata_w =
    hit_ctrl ? {22'h0, ctrl_reg} :
    hit_cmd  ? {16'h0, ind_reg, opc_reg} :
    hit_addr ? addr_reg :
    hit_len  ? {16'h0, len_reg} :
    hit_stat ? {28'h0, err_reg, enh_reg, rx_full_reg, busy} :
    hit_rxd  ? {24'h0, rx_reg} : 32'h0;

  // Per-command shape of the frame
  wire is_qio   = ctrl_reg.mode == MD_QIO;
  wire is_qddr  = ctrl_reg.mode == MD_QDDR;
  wire mode_ok  = ctrl_reg.mode inside {MD_QOR, MD_QIO, MD_SDDR, MD_DDDR, MD_QDDR};
  wire quad_io  = is_qio | is_qddr;
  wire qe_miss  = is_qddr & ~ctrl_reg.qe;
  wire xddr     = ctrl_reg.mode inside {MD_SDDR, MD_DDDR, MD_QDDR};
  wire [1:0] cmd_lw  = (quad_io & ctrl_reg.four_wire_command_mode) ? 2'h2 : 2'h0;
  wire [1:0] addr_lw = (ctrl_reg.mode == MD_QOR || ctrl_reg.mode == MD_SDDR) ? 2'h0 :
                       (ctrl_reg.mode == MD_DDDR) ? 2'h1 : 2'h2;
  wire [1:0] data_lw = (ctrl_reg.mode == MD_SDDR) ? 2'h0 :
                       (ctrl_reg.mode == MD_DDDR) ? 2'h1 : 2'h2;
  wire [7:0] abits   = ctrl_reg.wide ? `MFR_ADDR4_BITS : `MFR_ADDR3_BITS;
  wire [3:0] dum_def = (ctrl_reg.mode == MD_QOR) ? `MFR_DUMMY_QOR : `MFR_DUMMY_DEF;
  wire [3:0] dum_clk = (ctrl_reg.dummy == 4'h0) ? dum_def : ctrl_reg.dummy;
  wire [3:0] ind_clk = !quad_io ? 4'h0 : is_qddr ? `MFR_IND_DDR : `MFR_IND_SDR;
  wire [3:0] rem_clk = (dum_clk > ind_clk) ? dum_clk - ind_clk : 4'h0;
  wire [7:0] rem_bt  = xddr ? {3'h0, rem_clk, 1'b0} : {4'h0, rem_clk};
  wire mfr_state_t after_ind = (rem_clk != 4'h0) ? ST_DUMMY : ST_DATA;

  // Start, abort and enhance skip
  wire start     = wr & hit_go & pwdata[`MFR_GO_START] & ~busy;
  wire go_ok     = start & mode_ok & ~qe_miss;
  wire abort     = wr & hit_go & pwdata[`MFR_GO_ABORT];
  wire skip_cmd  = enh_reg & quad_io;
  wire ind_tog   = ind_reg[7:4] == ~ind_reg[3:0];

  // Half-period timing of the serial clock
  wire half_end  = hcnt_reg == HLAST;
  wire active    = state_reg inside {ST_CMD, ST_ADDR, ST_IND, ST_DUMMY, ST_DATA};
  wire stall     = (state_reg == ST_DATA) & bstart_reg & rx_full_reg;
  wire beat_end  = active & half_end & ~stall & (ddr_reg | half_reg);
  wire phase_end = beat_end & (beats_reg == 8'h01);
  wire byte_done = (state_reg == ST_DATA) & phase_end;
  wire [2:0] lines = 3'(1 << lw_reg);

  // Received bits; single line data arrives on the second line
  wire [7:0] rxsh_w = (lw_reg == 2'h2) ? {rxsh_reg[3:0], sio_s[3:0]} :
                      (lw_reg == 2'h1) ? {rxsh_reg[5:0], sio_s[1:0]} :
                                         {rxsh_reg[6:0], sio_s[1]};

  // Frame sequencer
  always_comb begin
    state_next = state_reg;
    load       = 1'b0;
    unique case (state_reg)
      ST_IDLE:  if (go_ok) state_next = ST_LEAD;
      ST_LEAD: begin
        if (half_end) begin
          load       = 1'b1;
          state_next = skip_cmd ? ST_ADDR : ST_CMD;
        end
      end
      ST_CMD: begin
        if (phase_end) begin
          load       = 1'b1;
          state_next = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (phase_end) begin
          load       = 1'b1;
          state_next = quad_io ? ST_IND : after_ind;
        end
      end
      ST_IND: begin
        if (phase_end) begin
          load       = 1'b1;
          state_next = after_ind;
        end
      end
      ST_DUMMY: begin
        if (phase_end) begin
          load       = 1'b1;
          state_next = ST_DATA;
        end
      end
      ST_DATA: begin
        if (phase_end) begin
          load       = 1'b1;
          state_next = (bytes_reg == 16'h0001) ? ST_TAIL : ST_DATA;
        end
      end
      ST_TAIL:  if (half_end) state_next = ST_IDLE;
    endcase
    // Empty read length closes the frame after the dummy cycles
    if (load && state_next == ST_DATA && state_reg != ST_DATA && len_reg == 16'h0000) begin
      state_next = ST_TAIL;
    end
    // Abort raises chip select at once, even mid-byte
    if (abort && busy && state_reg != ST_TAIL) begin
      state_next = ST_TAIL;
      load       = 1'b0;
    end
  end

  // Phase loading: counts, lane width, DDR and the out shifter
  always_comb begin
    beats_next = beats_reg;
    lw_next    = lw_reg;
    ddr_next   = ddr_reg;
    sh_next    = sh_reg;
    bytes_next = bytes_reg;
    if (beat_end) begin
      beats_next = beats_reg - 8'h01;
      sh_next    = sh_reg << lines;
    end
    if (load) begin
      unique case (state_next)
        ST_CMD: begin
          lw_next    = cmd_lw;
          ddr_next   = 1'b0;
          beats_next = `MFR_BYTE_BITS >> cmd_lw;
          sh_next    = {opc_reg, 24'h0};
        end
        ST_ADDR: begin
          lw_next    = addr_lw;
          ddr_next   = xddr;
          beats_next = abits >> addr_lw;
          sh_next    = ctrl_reg.wide ? addr_reg : {addr_reg[23:0], 8'h0};
        end
        ST_IND: begin
          lw_next    = addr_lw;
          ddr_next   = xddr;
          beats_next = `MFR_BYTE_BITS >> addr_lw;
          sh_next    = {ind_reg, 24'h0};
        end
        ST_DUMMY: begin
          lw_next    = data_lw;
          ddr_next   = xddr;
          beats_next = rem_bt;
          sh_next    = 32'h0;
        end
        ST_DATA: begin
          lw_next    = data_lw;
          ddr_next   = xddr;
          beats_next = `MFR_BYTE_BITS >> data_lw;
          bytes_next = (state_reg == ST_DATA) ? bytes_reg - 16'h0001 : len_reg;
        end
        default: begin
          beats_next = 8'h00;
        end
      endcase
    end
  end

  // Pin drive: lines are driven only for command, address and indicator
  wire drive  = state_reg inside {ST_CMD, ST_ADDR, ST_IND};
  wire [3:0] oe_w = !drive ? 4'h0 : (lw_reg == 2'h2) ? 4'hF :
                    (lw_reg == 2'h1) ? 4'h3 : 4'h1;
  wire [3:0] do_w = (lw_reg == 2'h2) ? sh_reg[31:28] :
                    (lw_reg == 2'h1) ? {2'h0, sh_reg[31:30]} : {3'h0, sh_reg[31]};

  // APB answer registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= ask;
      pslverr <= ask & ~mapped;
      prdata  <= (ask & ~pwrite) ? rdata_w : 32'h0;
    end
  end

  // Software registers; settings are used as they stand at frame start
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg <= mfr_ctrl_t'(`MFR_CTRL_RST);
      opc_reg  <= `MFR_BYTE_RST;
      ind_reg  <= `MFR_BYTE_RST;
      addr_reg <= 32'h0;
      len_reg  <= 16'h0;
    end else if (wr && !busy) begin
      if (hit_ctrl) ctrl_reg <= mfr_ctrl_t'(pwdata[`MFR_F_CTRL]);
      if (hit_cmd) opc_reg <= pwdata[`MFR_F_OPC];
      if (hit_cmd) ind_reg <= pwdata[`MFR_F_IND];
      if (hit_addr) addr_reg <= pwdata;
      if (hit_len) len_reg <= pwdata[`MFR_F_LEN];
    end
  end

  // Status flags; a byte landing wins over a read that clears
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rx_full_reg <= 1'b0;
      rx_reg      <= `MFR_BYTE_RST;
      err_reg     <= 1'b0;
      enh_reg     <= 1'b0;
    end else begin
      if (byte_done) rx_reg <= rxsh_w;
      rx_full_reg <= byte_done | (rx_full_reg & ~(rd & hit_rxd));
      if (start) err_reg <= ~go_ok;
      if (state_reg == ST_IND && phase_end) enh_reg <= ind_tog;
    end
  end

  // Sequencer and half-period counters
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg  <= ST_IDLE;
      hcnt_reg   <= '0;
      half_reg   <= 1'b0;
      bstart_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg && !load) begin
        hcnt_reg <= '0;
        half_reg <= 1'b0;
      end else if (!stall) begin
        hcnt_reg <= half_end ? '0 : hcnt_reg + 1'b1;
        if (half_end && active) half_reg <= ~half_reg;
      end
      if (load && state_next == ST_DATA) bstart_reg <= 1'b1;
      else if (!stall) bstart_reg <= 1'b0;
    end
  end

  // Shift paths
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      beats_reg <= 8'h00;
      bytes_reg <= 16'h0;
      sh_reg    <= 32'h0;
      lw_reg    <= 2'h0;
      ddr_reg   <= 1'b0;
      rxsh_reg  <= `MFR_BYTE_RST;
    end else begin
      beats_reg <= beats_next;
      bytes_reg <= bytes_next;
      sh_reg    <= sh_next;
      lw_reg    <= lw_next;
      ddr_reg   <= ddr_next;
      if (beat_end && state_reg == ST_DATA) rxsh_reg <= rxsh_w;
    end
  end

  // Pins, one clock behind the sequencer so they all move together
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sclk    <= 1'b0;
      cs_b    <= 1'b1;
      sio_drv <= '0;
    end else begin
      sclk    <= active & half_reg;
      cs_b    <= (state_reg == ST_IDLE) | (state_reg == ST_TAIL);
      sio_drv <= '{dout: do_w, oe: oe_w};
    end
  end

endmodule

// [hdl/mfr_cfg.svh]
`ifndef MFR_CFG_SVH
`define MFR_CFG_SVH
// Overview of operation
// - Quad output read: command and address single line, 8 dummy, data on four lines.
// - Host ends a read by raising chip select during the data phase.
// - Quad I/O read: single-line command, four-line address, 6 dummy, four-line data.
// - Quad I/O read also runs with the command sent on four lines.
// - Host keeps driving the data lines during the indicator clocks.
// - Single-line DDR read: address and data two bits per clock, 6 dummy.
// - DDR phases move bits on both clock edges, rising edge first.
// - Dual I/O DDR read: address and data four bits per clock, 6 dummy.
// - Host sets quad enable before issuing the quad I/O DDR read.
// - Quad I/O DDR read moves address and data eight bits per clock, four per edge.
// - Toggling indicator keeps enhance mode and skips the next command phase.

// Register offsets (byte addresses)
`define MFR_A_CTRL      8'h00
`define MFR_A_CMD       8'h04
`define MFR_A_ADDR      8'h08
`define MFR_A_LEN       8'h0C
`define MFR_A_GO        8'h10
`define MFR_A_STAT      8'h14
`define MFR_A_RXD       8'h18

// Field positions
`define MFR_F_CTRL      9:0
`define MFR_F_OPC       7:0
`define MFR_F_IND       15:8
`define MFR_F_LEN       15:0
`define MFR_GO_START    0
`define MFR_GO_ABORT    1

// Reset values
`define MFR_CTRL_RST    10'h000
`define MFR_BYTE_RST    8'h00

// Bit counts and dummy defaults
`define MFR_BYTE_BITS   8'h08
`define MFR_ADDR3_BITS  8'h18
`define MFR_ADDR4_BITS  8'h20
`define MFR_DUMMY_QOR   4'h8
`define MFR_DUMMY_DEF   4'h6
`define MFR_IND_SDR     4'h2
`define MFR_IND_DDR     4'h1
`endif

// [hdl/mfr_pkg.sv]
package mfr_pkg;

  // Read command kinds selected by software
  typedef enum logic [2:0] {
    MD_QOR,
    MD_QIO,
    MD_SDDR,
    MD_DDDR,
    MD_QDDR
  } mfr_mode_t;

  // Frame sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LEAD,
    ST_CMD,
    ST_ADDR,
    ST_IND,
    ST_DUMMY,
    ST_DATA,
    ST_TAIL
  } mfr_state_t;

  // Control register layout, low bits first at the bottom
  typedef struct packed {
    logic [3:0] dummy;
    logic       qe;
    logic       four_wire_command_mode;
    logic       wide;
    mfr_mode_t  mode;
  } mfr_ctrl_t;

  // Data line drive bundle
  typedef struct packed {
    logic [3:0] dout;
    logic [3:0] oe;
  } mfr_sio_t;

endpackage

// [hdl/mfr_sync.sv]
module mfr_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst_b,
  // Asynchronous in, synchronised out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // Two stages; the first feeds only the second
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

// [verification/mfr_flash_model.sv]
module mfr_flash_model (
  // Clock and serial pins
  input  wire logic       clock,
  input  wire logic       sclk,
  input  wire logic       cs_b,
  input  wire logic [3:0] lv,
  // Line drive of the device
  output logic      [3:0] dev
);
  timeunit 1ns;
  timeprecision 1ps;
  int         nrise = 0;
  int         nfall = 0;
  logic [3:0] hist [64];
  logic [3:0] hfall [64];
  logic [3:0] lv_q = 4'h0;
  logic       sclk_q = 1'b0;
  logic       cs_q = 1'b1;
  logic [3:0] drv = 4'h6;

  // Never busy; edges found one clock late with the lines as they stood before the edge,
  // since in DDR phases the host moves the lines together with the serial clock
  always @(posedge clock) begin
    lv_q   <= lv;
    sclk_q <= sclk;
    cs_q   <= cs_b;
    if (cs_q && !cs_b) begin
      nrise <= 0;
      nfall <= 0;
    end else if (!cs_b && sclk && !sclk_q && nrise < 64) begin
      hist[nrise] <= lv_q;
      nrise       <= nrise + 1;
    end else if (!cs_b && !sclk && sclk_q && nfall < 64) begin
      hfall[nfall] <= lv_q;
      nfall        <= nfall + 1;
    end
  end

  // Same pattern at every address and in dummy cycles, so wrapped reads and preamble
  // bits look alike; lines hold 4'h6 while selected and flip every cycle only while chip select is high
  always @(posedge clock) begin
    drv <= cs_b ? ~drv : 4'h6;
  end
  assign dev = drv;
endmodule

// [verification/mfr_chk.sv]
`include "mfr_cfg.svh"

module mfr_chk
  import mfr_pkg::*;
#(
  parameter int HALF = 4
) (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_b,
  // Bus side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Flash side
  input wire logic        sclk,
  input wire logic        cs_b,
  input wire mfr_sio_t    sio_drv,
  input wire logic [3:0]  sio_in
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  // Completed writes and the start/abort register
  logic       xfer_w;
  logic       go_w;
  logic [9:0] ctrl_q;
  assign xfer_w = psel && penable && pready && pwrite;
  assign go_w   = xfer_w && paddr == `MFR_A_GO;

  // Shadow of the control word; bench only writes it while idle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= 10'h000;
    end else if (xfer_w && paddr == `MFR_A_CTRL && cs_b) begin
      ctrl_q <= pwdata[9:0];
    end
  end

  chk_wait_one: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  chk_slverr_map: assert property (pready && paddr > 8'h18 |-> pslverr)
    else $error("unmapped address not flagged");
  chk_abort_cs: assert property (go_w && pwdata[1] |-> ##[1:2] (cs_b && !sclk))
    else $error("abort did not end frame");
  chk_qe_block: assert property (go_w && pwdata[0] && ctrl_q[2:0] == 3'h4 && !ctrl_q[5]
    |=> cs_b[*4]) else $error("quad DDR frame began without quad enable");
  chk_cs_gap: assert property ($rose(cs_b) |-> cs_b[*4])
    else $error("chip select gap too short");
  chk_half_high: assert property ($fell(sclk) && !cs_b
    |-> $past(sclk, HALF) && !$past(sclk, HALF + 1)) else $error("sclk high half wrong");
  chk_idle_quiet: assert property (cs_b && $past(cs_b) |-> !sclk && sio_drv.oe == 4'h0)
    else $error("pins active while deselected");
endmodule

bind mfr_host mfr_chk #(.HALF(HALF)) u_chk (
  .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sclk(sclk), .cs_b(cs_b), .sio_drv(sio_drv), .sio_in(sio_in)
);

// [verification/tb_top.sv]
`include "mfr_cfg.svh"

module tb_top;
  import mfr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0]  OPC  = 8'h3C;
  localparam logic [31:0] ADR  = 32'h00A1B2C3;
  localparam logic [31:0] WADR = 32'h7E5D4C3B;
  logic        clock, rst_b, psel, penable, pwrite, pready, pslverr, sclk, cs_b;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [42:0] req;
  logic [3:0]  sio_in, dev;
  mfr_sio_t    sio_drv;
  int          checks = 0;
  int          failures = 0;
  int          cyc = 0;

  // Bus request fields move together; wire level from host enables else device
  assign {psel, penable, pwrite, paddr, pwdata} = req;
  assign sio_in = (sio_drv.oe & sio_drv.dout) | (~sio_drv.oe & dev);

  mfr_host #(.HALF(4)) uut (
    .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sclk(sclk), .cs_b(cs_b), .sio_drv(sio_drv), .sio_in(sio_in)
  );
  mfr_flash_model fm (.clock(clock), .sclk(sclk), .cs_b(cs_b), .lv(sio_in), .dev(dev));

  // System clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    req <= {1'b1, 1'b0, w, a, d};
    @(posedge clock);
    req <= {1'b1, 1'b1, w, a, d};
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      $display("[ERR] %0t no pready", $time);
    end
    r = prdata;
    e = pslverr;
    req <= 43'h0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask

  // Rebuild a value from logged rising-edge line levels, one or four lines
  function automatic logic [31:0] cap(input int s, input int n, input int w);
    logic [31:0] v;
    v = 32'h0;
    for (int i = s; i < s + n; i++) begin
      v = (w == 4) ? {v[27:0], fm.hist[i]} : {v[30:0], fm.hist[i][0]};
    end
    return v;
  endfunction

  // Rebuild a DDR value, rising-edge group first, from the low w lines of each edge
  function automatic logic [31:0] capd(input int s, input int n, input int w);
    logic [31:0] v;
    logic [3:0]  m;
    v = 32'h0;
    m = 4'((1 << w) - 1);
    for (int i = s; i < s + n; i++) begin
      v = (v << w) | {28'h0, fm.hist[i] & m};
      v = (v << w) | {28'h0, fm.hfall[i] & m};
    end
    return v;
  endfunction

  // Status reads until the masked bits match; running out counts as a mismatch
  task automatic poll(input logic [31:0] m, input logic [31:0] v, output logic [31:0] st);
    int n;
    n = 0;
    do begin
      rd(`MFR_A_STAT, st);
      n++;
    end while ((st & m) !== v && n < 300);
    if ((st & m) !== v) begin
      failures++;
      $display("[ERR] %0t status wait ran out", $time);
    end
  endtask

  // One-byte read frame; checks clock count and received byte
  task automatic frame(input logic [9:0] c, input logic [7:0] ind, input logic [31:0] a,
                       input int nr, input logic [7:0] rx, output logic [31:0] st);
    logic [31:0] r;
    wr(`MFR_A_CTRL, {22'h0, c});
    wr(`MFR_A_CMD, {16'h0, ind, OPC});
    wr(`MFR_A_ADDR, a);
    wr(`MFR_A_LEN, 32'h1);
    wr(`MFR_A_GO, 32'h1);
    poll(32'h1, 32'h0, st);
    chk(fm.nrise, nr);
    rd(`MFR_A_RXD, r);
    chk(r, {24'h0, rx});
  endtask

  task automatic t_regs();
    logic [31:0] r;
    logic        e;
    rd(`MFR_A_CTRL, r);
    chk(r, 32'h0);
    wr(`MFR_A_CTRL, 32'hFFFF_FFFF);
    rd(`MFR_A_CTRL, r);
    chk(r, 32'h3FF);
    apb(1'b0, 8'h1C, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    rd(`MFR_A_GO, r);
    chk(r, 32'h0);
    $display("register test done");
  endtask

  task automatic t_single();
    logic [31:0] st;
    frame(10'h000, 8'h00, ADR, 42, 8'h66, st);
    chk(cap(0, 32, 1), {OPC, ADR[23:0]});
    frame(10'h008, 8'h00, WADR, 50, 8'h66, st);
    chk(cap(8, 32, 1), WADR);
    $display("single-line address test done");
  endtask

  task automatic t_quad_io();
    logic [31:0] st;
    frame(10'h001, 8'hA5, ADR, 22, 8'h66, st);
    chk(cap(8, 6, 4), {8'h0, ADR[23:0]});
    chk(st & 32'h4, 32'h4);
    frame(10'h001, 8'hFF, WADR, 14, 8'h66, st);
    chk(cap(0, 6, 4), {8'h0, WADR[23:0]});
    chk(st & 32'h4, 32'h0);
    frame(10'h281, 8'h00, ADR, 26, 8'h66, st);
    frame(10'h011, 8'h00, ADR, 16, 8'h66, st);
    chk(cap(0, 2, 4), {24'h0, OPC});
    $display("quad io test done");
  endtask

  task automatic t_ddr();
    logic [31:0] st;
    wr(`MFR_A_CTRL, 32'h4);
    wr(`MFR_A_GO, 32'h1);
    rd(`MFR_A_STAT, st);
    chk(st & 32'h9, 32'h8);
    frame(10'h024, 8'h00, ADR, 18, 8'h66, st);
    chk(capd(8, 3, 4), {8'h0, ADR[23:0]});
    chk(st & 32'h8, 32'h0);
    frame(10'h034, 8'h00, ADR, 12, 8'h66, st);
    chk(capd(2, 3, 4), {8'h0, ADR[23:0]});
    frame(10'h002, 8'h00, ADR, 30, 8'hFF, st);
    chk(capd(8, 12, 1), {8'h0, ADR[23:0]});
    frame(10'h003, 8'h00, ADR, 22, 8'hAA, st);
    chk(capd(8, 6, 2), {8'h0, ADR[23:0]});
    $display("double rate test done");
  endtask

  // Abort while the clock is held back by an unread byte
  task automatic t_abort();
    logic [31:0] r;
    int          k;
    wr(`MFR_A_CTRL, 32'h0);
    wr(`MFR_A_LEN, 32'h4);
    wr(`MFR_A_GO, 32'h1);
    poll(32'h2, 32'h2, r);
    chk(fm.nrise, 42);
    wr(`MFR_A_GO, 32'h2);
    repeat (4) @(posedge clock);
    k = fm.nrise;
    chk({31'h0, cs_b}, 32'h1);
    repeat (40) @(posedge clock);
    chk(fm.nrise, k);
    rd(`MFR_A_STAT, r);
    chk(r & 32'h1, 32'h0);
    // Empty length: frame closes right after the dummy clocks
    wr(`MFR_A_LEN, 32'h0);
    wr(`MFR_A_GO, 32'h1);
    poll(32'h1, 32'h0, r);
    chk(fm.nrise, 40);
    $display("abort test done");
  endtask

  // Main sequence
  initial begin
    rst_b = 1'b0;
    req = 43'h0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    t_regs();
    t_single();
    t_quad_io();
    t_ddr();
    t_abort();
    finish_test();
  end
endmodule
